// ---- btmx_pkg.sv ----
package btmx_pkg;
	// register byte addresses (16-bit registers, one per address)
	localparam logic [7:0] ROUTE_SELECT_ADDR = 8'h6e;
	localparam logic [7:0] CONTROL_ZERO_ADDR = 8'h70;
	localparam logic [7:0] BIT_SNAP_LO_ADDR = 8'h78;
	localparam logic [7:0] BIT_SNAP_HI_ADDR = 8'h7a;
	localparam logic [7:0] ERR_SNAP_LO_ADDR = 8'h7c;
	localparam logic [7:0] ERR_SNAP_HI_ADDR = 8'h7e;
	localparam logic [7:0] LOCK_STATUS_ADDR = 8'h80;
	localparam logic [15:0] ROUTE_SELECT_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_ZERO_RESET = 16'h0000;
	// field layout of the route register
	localparam int RX_SEL_LSB = 0;
	localparam int TX_SEL_LSB = 8;
	localparam int SEL_WIDTH = 5;
	// writable bits: route fields, and everything but bit 12 in control
	localparam logic [15:0] ROUTE_SELECT_MASK = 16'h1f1f;
	localparam logic [15:0] CONTROL_ZERO_MASK = 16'hefff;
	localparam int RELOCK_BIT = 0;
	localparam int LATCH_BIT = 1;
	// selector codes
	localparam logic [4:0] SEL_NONE = 5'h00;
	localparam logic [4:0] SEL_LAST_PORT = 5'h1c;
	localparam logic [4:0] SEL_HR_PAYLOAD = 5'h1d;
	localparam logic [4:0] SEL_HR_ALL = 5'h1e;
	localparam logic [4:0] SEL_ILLEGAL = 5'h1f;
	localparam int NUM_PORTS = 28;
	localparam int BIT_COUNT_WIDTH = 32;
	localparam int ERR_COUNT_WIDTH = 24;
	// sync detector: matching bits needed to declare lock
	localparam logic [5:0] LOCK_RUN = 6'h20;
	localparam logic [5:0] LOCK_RUN_ZERO = 6'h00;
	localparam logic [5:0] LOCK_RUN_ONE = 6'h01;
	typedef enum logic [1:0] {RX_HUNT, RX_LOCKED} btmx_rx_state_type;
endpackage

// ---- btmx_snapshot.sv ----
`timescale 1ns/1ps
// holds the latched counts; read data always come out of a register
module btmx_snapshot (
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic load, // one-cycle latch pulse
	input wire logic [31:0] bitIn, // running bit count
	input wire logic [23:0] errIn, // running error count
	output logic [31:0] bitSnap, // latched bit count
	output logic [23:0] errSnap // latched error count
);
	// capture on the latch pulse only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bitSnap <= 32'h0000_0000;
			errSnap <= 24'h00_0000;
		end else if (load) begin
			bitSnap <= bitIn;
			errSnap <= errIn;
		end
	end
endmodule // btmx_snapshot

// ---- btmx_mux_control.sv ----
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// (RULE1) five-bit field picks tester receive source
// (RULE2) zero none, 1..28 ports, 31 illegal
// (RULE3) code 29 feeds high-rate payload only
// (RULE4) code 30 feeds all high-rate bits
// (RULE5) five-bit field picks transmit replace target
// (RULE6) code 29 replaces payload bits only
// (RULE7) code 30 replaces every high-rate bit
// (RULE8) relock bit rising edge restarts lock hunt
// (RULE9) host raises relock for a new pattern
// (RULE10) only rising edge acts; clear then set
// (RULE11) latch rising edge snapshots and clears counters
// (RULE12) host toggles latch bit per interval
// (RULE13) bit counter 32 bits, errors 24 bits
// (RULE14) edges found against previous registered bit
module btmx_mux_control (
	input wire logic clk_sys, // system clock, 25 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic [7:0] regAddr, // register byte address
	input wire logic [15:0] regWdata, // write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	output logic [15:0] regRdata, // read data, cycle after strobe
	input wire logic [27:0] tribRxData, // tributary receive bits
	input wire logic [27:0] tribRxValid, // tributary receive strobes
	input wire logic hrRxData, // high-rate receive bit
	input wire logic hrRxValid, // high-rate receive strobe
	input wire logic hrRxOverhead, // high-rate bit is overhead
	input wire logic testRefBit, // expected pattern bit
	output logic testRxData, // bit to tester receiver
	output logic testRxValid, // tester receive strobe
	input wire logic testTxData, // generated tester bit
	input wire logic [27:0] tribTxData, // normal tributary transmit bits
	input wire logic [27:0] tribTxValid, // tributary transmit strobes
	output logic [27:0] tribTxOut, // tributary transmit after replace
	input wire logic hrTxData, // normal high-rate transmit bit
	input wire logic hrTxValid, // high-rate transmit strobe
	input wire logic hrTxOverhead, // high-rate bit is overhead
	output logic hrTxOut, // high-rate transmit after replace
	output logic testTxTake, // tester bit consumed this cycle
	output logic relockPulse, // one-cycle relock request
	output logic rxLocked // tester receiver in lock
);
	logic [15:0] routeSelect_reg;
	logic [15:0] controlZero_reg;
	logic relockPrev_reg;
	logic latchPrev_reg;
	logic latchPulse;
	logic [4:0] rxSel;
	logic [4:0] txSel;
	logic [31:0] bitCount_reg;
	logic [23:0] errCount_reg;
	logic [31:0] bitSnap;
	logic [23:0] errSnap;
	logic [5:0] lockRun_reg;
	btmx_pkg::btmx_rx_state_type rxState_reg;
	logic rxBit;
	logic rxStrobe;
	logic txStrobe;
	logic [15:0] rdNext;
	logic [4:0] txPortSel;

	// passes a tributary port selector 1..28 through unchanged, 0 for any other code
	function automatic logic [4:0] port_code(input logic [4:0] code);
		if (code != btmx_pkg::SEL_NONE && code <= btmx_pkg::SEL_LAST_PORT)
			return code;
		return btmx_pkg::SEL_NONE;
	endfunction

	function automatic logic [4:0] port_index(input logic [4:0] code);
		return 5'(code - 5'h01);
	endfunction

	assign rxSel = routeSelect_reg[btmx_pkg::RX_SEL_LSB +: btmx_pkg::SEL_WIDTH]; // see (RULE1)
	assign txSel = routeSelect_reg[btmx_pkg::TX_SEL_LSB +: btmx_pkg::SEL_WIDTH]; // see (RULE5)

	// host register writes; reserved bits stay zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			routeSelect_reg <= btmx_pkg::ROUTE_SELECT_RESET;
			controlZero_reg <= btmx_pkg::CONTROL_ZERO_RESET;
		end else if (regWr) begin
			if (regAddr == btmx_pkg::ROUTE_SELECT_ADDR)
				routeSelect_reg <= regWdata & btmx_pkg::ROUTE_SELECT_MASK;
			if (regAddr == btmx_pkg::CONTROL_ZERO_ADDR)
				controlZero_reg <= regWdata & btmx_pkg::CONTROL_ZERO_MASK;
		end
	end

	// edge detect against the previous registered value
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			relockPrev_reg <= 1'b0; // see (RULE14)
			latchPrev_reg <= 1'b0;
		end else begin
			relockPrev_reg <= controlZero_reg[btmx_pkg::RELOCK_BIT];
			latchPrev_reg <= controlZero_reg[btmx_pkg::LATCH_BIT];
		end
	end
	// a level held high never retriggers: host must clear first
	assign relockPulse = controlZero_reg[btmx_pkg::RELOCK_BIT]
		& ~relockPrev_reg; // see (RULE8) see (RULE10) see (RULE14)
	assign latchPulse = controlZero_reg[btmx_pkg::LATCH_BIT]
		& ~latchPrev_reg; // see (RULE11) see (RULE10)

	// receive source mux; illegal and none deliver nothing
	always_comb begin
		rxBit = 1'b0;
		rxStrobe = 1'b0;
		if (port_code(rxSel) != btmx_pkg::SEL_NONE) begin
			rxBit = tribRxData[port_index(rxSel)]; // see (RULE2)
			rxStrobe = tribRxValid[port_index(rxSel)];
		end else if (rxSel == btmx_pkg::SEL_HR_PAYLOAD) begin
			rxBit = hrRxData;
			rxStrobe = hrRxValid & ~hrRxOverhead; // see (RULE3)
		end else if (rxSel == btmx_pkg::SEL_HR_ALL) begin
			rxBit = hrRxData;
			rxStrobe = hrRxValid; // see (RULE4)
		end
	end

	// registered tester feed; data outputs come from flip-flops
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			testRxData <= 1'b0;
			testRxValid <= 1'b0;
		end else begin
			testRxData <= rxBit;
			testRxValid <= rxStrobe;
		end
	end

	// transmit replacement; overhead kept normal in payload-only mode
	assign txPortSel = port_code(txSel);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tribTxOut <= 28'h000_0000;
			hrTxOut <= 1'b0;
		end else begin
			for (int i = 0; i < btmx_pkg::NUM_PORTS; i++) begin
				if (txPortSel != btmx_pkg::SEL_NONE
					&& port_index(txPortSel) == 5'(i))
					tribTxOut[i] <= testTxData; // see (RULE5)
				else
					tribTxOut[i] <= tribTxData[i];
			end
			if (txSel == btmx_pkg::SEL_HR_ALL)
				hrTxOut <= testTxData; // see (RULE7)
			else if (txSel == btmx_pkg::SEL_HR_PAYLOAD && !hrTxOverhead)
				hrTxOut <= testTxData; // see (RULE6)
			else
				hrTxOut <= hrTxData;
		end
	end

	// tells the generator when its bit was used, so it advances
	always_comb begin
		txStrobe = 1'b0;
		if (txPortSel != btmx_pkg::SEL_NONE)
			txStrobe = tribTxValid[port_index(txPortSel)];
		else if (txSel == btmx_pkg::SEL_HR_ALL)
			txStrobe = hrTxValid; // see (RULE7)
		else if (txSel == btmx_pkg::SEL_HR_PAYLOAD)
			txStrobe = hrTxValid & ~hrTxOverhead; // see (RULE6)
	end
	assign testTxTake = txStrobe;

	// lock hunt: needs a run of matches; relock throws lock away
	always_ff @(posedge clk_sys) begin
		if (rst || relockPulse) begin
			rxState_reg <= btmx_pkg::RX_HUNT; // see (RULE8)
			lockRun_reg <= btmx_pkg::LOCK_RUN_ZERO;
		end else if (testRxValid) begin
			unique case (rxState_reg)
			btmx_pkg::RX_HUNT: begin
				if (testRxData != testRefBit)
					lockRun_reg <= btmx_pkg::LOCK_RUN_ZERO;
				else if (lockRun_reg
					== btmx_pkg::LOCK_RUN - btmx_pkg::LOCK_RUN_ONE)
					rxState_reg <= btmx_pkg::RX_LOCKED;
				else
					lockRun_reg <= lockRun_reg + btmx_pkg::LOCK_RUN_ONE;
			end
			btmx_pkg::RX_LOCKED: begin
				lockRun_reg <= btmx_pkg::LOCK_RUN_ZERO;
			end
			endcase
		end
	end
	assign rxLocked = (rxState_reg == btmx_pkg::RX_LOCKED);

	// running counters, cleared by the latch; latch beats a new bit
	always_ff @(posedge clk_sys) begin
		if (rst || latchPulse) begin
			bitCount_reg <= 32'h0000_0000; // see (RULE11) see (RULE13)
			errCount_reg <= 24'h00_0000;
		end else if (testRxValid && rxLocked) begin
			bitCount_reg <= bitCount_reg + 32'h0000_0001;
			if (testRxData != testRefBit)
				errCount_reg <= errCount_reg + 24'h00_0001;
		end
	end

	btmx_snapshot snapshot (
		.clk_sys(clk_sys),
		.rst(rst),
		.load(latchPulse), // see (RULE11)
		.bitIn(bitCount_reg),
		.errIn(errCount_reg),
		.bitSnap(bitSnap),
		.errSnap(errSnap)
	);

	// read decode; unmapped addresses read zero
	always_comb begin
		unique case (regAddr)
		btmx_pkg::ROUTE_SELECT_ADDR: rdNext = routeSelect_reg;
		btmx_pkg::CONTROL_ZERO_ADDR: rdNext = controlZero_reg;
		btmx_pkg::BIT_SNAP_LO_ADDR: rdNext = bitSnap[15:0];
		btmx_pkg::BIT_SNAP_HI_ADDR: rdNext = bitSnap[31:16];
		btmx_pkg::ERR_SNAP_LO_ADDR: rdNext = errSnap[15:0];
		btmx_pkg::ERR_SNAP_HI_ADDR: rdNext = {8'h00, errSnap[23:16]};
		btmx_pkg::LOCK_STATUS_ADDR: rdNext = {15'h0000, rxLocked};
		default: rdNext = 16'h0000;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (rst)
			regRdata <= 16'h0000;
		else if (regRd)
			regRdata <= rdNext;
		else
			regRdata <= 16'h0000;
	end

	// checks
	property p_relock_edge;
		@(posedge clk_sys) disable iff (rst)
		(regWr && regAddr == btmx_pkg::CONTROL_ZERO_ADDR
			&& regWdata[btmx_pkg::RELOCK_BIT]
			&& !controlZero_reg[btmx_pkg::RELOCK_BIT])
			|=> relockPulse ##1 !relockPulse;
	endproperty
	a_relock_edge: assert property (p_relock_edge) // see (RULE8)
		else $error("relock edge missed");

	property p_no_retrigger;
		@(posedge clk_sys) disable iff (rst)
		relockPulse |=> !relockPulse;
	endproperty
	a_no_retrigger: assert property (p_no_retrigger) // see (RULE10)
		else $error("relock retriggered");

	property p_relock_hunt;
		@(posedge clk_sys) disable iff (rst)
		relockPulse |=> !rxLocked;
	endproperty
	a_relock_hunt: assert property (p_relock_hunt) // see (RULE8)
		else $error("lock kept after relock");

	// clear and capture must both come from the one latch edge
	property p_latch_clear;
		@(posedge clk_sys) disable iff (rst)
		latchPulse |=> bitCount_reg == 32'h0000_0000
			&& errCount_reg == 24'h00_0000
			&& bitSnap == $past(bitCount_reg)
			&& errSnap == $past(errCount_reg);
	endproperty
	a_latch_clear: assert property (p_latch_clear) // see (RULE11)
		else $error("latch failed");

	// pulse only where the control bit was low one cycle before
	property p_latch_edge;
		@(posedge clk_sys) disable iff (rst)
		latchPulse |-> controlZero_reg[btmx_pkg::LATCH_BIT]
			&& !$past(controlZero_reg[btmx_pkg::LATCH_BIT]);
	endproperty
	a_latch_edge: assert property (p_latch_edge) // see (RULE14)
		else $error("latch without edge");

	property p_rx_none;
		@(posedge clk_sys) disable iff (rst)
		(rxSel == btmx_pkg::SEL_NONE || rxSel == btmx_pkg::SEL_ILLEGAL)
			|=> !testRxValid;
	endproperty
	a_rx_none: assert property (p_rx_none) // see (RULE2)
		else $error("data with no source");

	property p_rx_payload;
		@(posedge clk_sys) disable iff (rst)
		(rxSel == btmx_pkg::SEL_HR_PAYLOAD && hrRxOverhead) |=> !testRxValid;
	endproperty
	a_rx_payload: assert property (p_rx_payload) // see (RULE3)
		else $error("overhead passed");

	property p_rx_all;
		@(posedge clk_sys) disable iff (rst)
		(rxSel == btmx_pkg::SEL_HR_ALL && hrRxValid)
			|=> testRxValid && testRxData == $past(hrRxData);
	endproperty
	a_rx_all: assert property (p_rx_all) // see (RULE4)
		else $error("high-rate bit lost");

	property p_tx_payload;
		@(posedge clk_sys) disable iff (rst)
		(txSel == btmx_pkg::SEL_HR_PAYLOAD && hrTxOverhead)
			|=> hrTxOut == $past(hrTxData);
	endproperty
	a_tx_payload: assert property (p_tx_payload) // see (RULE6)
		else $error("overhead replaced");

	property p_tx_all;
		@(posedge clk_sys) disable iff (rst)
		txSel == btmx_pkg::SEL_HR_ALL |=> hrTxOut == $past(testTxData);
	endproperty
	a_tx_all: assert property (p_tx_all) // see (RULE7)
		else $error("high-rate not replaced");
endmodule // btmx_mux_control

// ---- btmx_path_model.sv ----
`timescale 1ns/1ps
// far-side data paths: tributary and high-rate streams, pattern generator
module btmx_path_model (
	input wire logic clk_sys, // system clock
	output logic [27:0] tribRxData, // tributary receive bits
	output logic [27:0] tribRxValid, // tributary receive strobes
	output logic hrRxData, // high-rate receive bit
	output logic hrRxValid, // high-rate receive strobe
	output logic hrRxOverhead, // high-rate overhead flag
	output logic testRefBit, // expected pattern bit
	output logic testTxData, // generated bit
	output logic [27:0] tribTxData, // normal tributary transmit bits
	output logic [27:0] tribTxValid, // tributary transmit strobes
	output logic hrTxData, // normal high-rate transmit bit
	output logic hrTxValid, // high-rate transmit strobe
	output logic hrTxOverhead // high-rate overhead flag
);
	// quiet at start; reference low until a test sets it
	initial begin
		{tribRxData, tribRxValid, hrRxData, hrRxValid, hrRxOverhead} = '0;
		{testRefBit, testTxData, tribTxData, tribTxValid} = '0;
		{hrTxData, hrTxValid, hrTxOverhead} = '0;
	end
	// one beat on every path, called just after a rising edge
	task automatic drive(input logic [27:0] rv, input logic [27:0] rd,
		input logic [2:0] hr, input logic [27:0] tv, input logic [27:0] td,
		input logic [2:0] ht, input logic gen);
		tribRxValid <= rv;
		tribRxData <= rd;
		{hrRxValid, hrRxData, hrRxOverhead} <= hr;
		tribTxValid <= tv;
		tribTxData <= td;
		{hrTxValid, hrTxData, hrTxOverhead} <= ht;
		testTxData <= gen;
	endtask
	// reference bit that the receiver compares against
	task automatic set_ref(input logic r);
		testRefBit <= r;
	endtask
	// released receive data flip, so a stale bit never passes for a fresh one
	task automatic release_all();
		tribRxValid <= '0;
		tribRxData <= ~tribRxData;
		hrRxValid <= 1'b0;
		hrRxData <= ~hrRxData;
		tribTxValid <= '0;
		hrTxValid <= 1'b0;
	endtask
endmodule // btmx_path_model

// ---- bert_mux_and_sync_control_tb.sv ----
`timescale 1ns/1ps
// host-side tests of tester routing, relock and count latching
module bert_mux_and_sync_control_tb;
	localparam logic [7:0] RS = btmx_pkg::ROUTE_SELECT_ADDR;
	localparam logic [7:0] CZ = btmx_pkg::CONTROL_ZERO_ADDR;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [15:0] regWdata = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [15:0] regRdata;
	logic [27:0] tribRxData, tribRxValid, tribTxData, tribTxValid, tribTxOut;
	logic hrRxData, hrRxValid, hrRxOverhead, testRefBit, testRxData;
	logic testRxValid, testTxData, hrTxData, hrTxValid, hrTxOverhead;
	logic hrTxOut, testTxTake, relockPulse, rxLocked;
	int nFail = 0;
	int nTests = 0;
	// 25 MHz system clock
	always #20 clk_sys = ~clk_sys;
	btmx_mux_control btmx_mux_control_i (.clk_sys, .rst, .regAddr, .regWdata,
		.regWr, .regRd, .regRdata, .tribRxData, .tribRxValid, .hrRxData,
		.hrRxValid, .hrRxOverhead, .testRefBit, .testRxData, .testRxValid,
		.testTxData, .tribTxData, .tribTxValid, .tribTxOut, .hrTxData,
		.hrTxValid, .hrTxOverhead, .hrTxOut, .testTxTake, .relockPulse,
		.rxLocked);
	btmx_path_model btmx_path_model_i (.clk_sys, .tribRxData, .tribRxValid,
		.hrRxData, .hrRxValid, .hrRxOverhead, .testRefBit, .testTxData,
		.tribTxData, .tribTxValid, .hrTxData, .hrTxValid, .hrTxOverhead);
	// compare helpers, four-state exact
	task automatic note(input string w, input logic bad, input logic [27:0] e,
		input logic [27:0] g);
		nTests++;
		if (bad) begin
			nFail++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic chk_reg(input string w, input logic [15:0] e,
		input logic [15:0] g);
		note(w, g !== e, {12'h000, e}, {12'h000, g});
	endtask
	task automatic chk_bit(input string w, input logic e, input logic g);
		note(w, g !== e, {27'h0000000, e}, {27'h0000000, g});
	endtask
	task automatic chk_vec(input string w, input logic [27:0] e,
		input logic [27:0] g);
		note(w, g !== e, e, g);
	endtask
	// register bus: one-cycle strobes, read data only in the next cycle
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
		#1;
	endtask
	task automatic rd(input string w, input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		chk_reg(w, e, regRdata);
	endtask
	// one high-rate receive bit, overhead clear; reference held at one
	// so a receiver that ignored its reference could never lock
	task automatic hr_bit(input logic d);
		@(posedge clk_sys);
		btmx_path_model_i.drive('0, '0, {1'b1, d, 1'b0}, '0, '0,
			3'b000, 1'b0);
		btmx_path_model_i.set_ref(1'b1);
	endtask
	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			btmx_path_model_i.release_all();
		end
	endtask
	// every path active at once; only the selected one may come through
	task automatic beat(input logic [4:0] c, input logic ovh);
		logic [27:0] hot;
		logic trib;
		logic hr;
		hot = (c >= 5'h01 && c <= 5'h1c) ? 28'h0000001 << (c - 5'h01) : '0;
		trib = |hot;
		hr = (c == btmx_pkg::SEL_HR_ALL)
			|| (c == btmx_pkg::SEL_HR_PAYLOAD && !ovh);
		@(posedge clk_sys);
		btmx_path_model_i.drive('1, hot, {1'b1, !trib, ovh}, '1, '0,
			{1'b1, 1'b0, ovh}, 1'b1);
		#1;
		chk_bit("tx take", trib | hr, testTxTake);
		quiet(1);
		#1;
		chk_bit("rx valid", trib | hr, testRxValid);
		if (trib | hr) begin
			chk_bit("rx data", 1'b1, testRxData);
		end
		chk_vec("trib out", hot, tribTxOut);
		chk_bit("hr out", hr, hrTxOut);
	endtask
	// print counts and verdict, then stop
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rd("route reset", RS, 16'h0000);
		rd("control reset", CZ, 16'h0000);
		wr(RS, 16'hffff);
		rd("route mask", RS, 16'h1f1f);
		wr(CZ, 16'hffff);
		rd("control mask", CZ, 16'hefff);
		wr(CZ, 16'h0000);
		rd("unmapped", 8'h72, 16'h0000);
		$display("test registers done");
		for (int c = 0; c < 32; c++) begin
			wr(RS, {3'b000, 5'(c), 3'b000, 5'(c)});
			beat(5'(c), 1'b1);
			beat(5'(c), 1'b0);
		end
		$display("test routing done");
		wr(CZ, 16'h0001);
		chk_bit("relock pulse", 1'b1, relockPulse);
		@(posedge clk_sys);
		#1;
		chk_bit("relock width", 1'b0, relockPulse);
		wr(CZ, 16'h0001);
		chk_bit("relock level", 1'b0, relockPulse);
		wr(CZ, 16'h0000);
		wr(CZ, 16'h0001);
		chk_bit("relock again", 1'b1, relockPulse);
		$display("test relock done");
		// 40 matching bits: 32 to lock, the rest counted before the latch
		wr(RS, 16'h001e);
		repeat (40) hr_bit(1'b1);
		quiet(3);
		chk_bit("locked", 1'b1, rxLocked);
		wr(CZ, 16'h0003);
		// 20 bits against a reference of one, three of them wrong
		for (int i = 0; i < 20; i++) hr_bit(i % 7 != 3);
		quiet(4);
		wr(CZ, 16'h0001);
		wr(CZ, 16'h0003);
		rd("bits low", 8'h78, 16'h0014);
		rd("bits high", 8'h7a, 16'h0000);
		rd("errors low", 8'h7c, 16'h0003);
		rd("errors high", 8'h7e, 16'h0000);
		$display("test counts done");
		// reset in mid-run must drop lock, route and snapshots
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		chk_bit("lock after reset", 1'b0, rxLocked);
		rd("route after reset", RS, 16'h0000);
		rd("bits after reset", 8'h78, 16'h0000);
		$display("test reset done");
		summarize();
	end
	// cut a hang short, far past the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys);
		nFail++;
		summarize();
	end
endmodule // bert_mux_and_sync_control_tb
